// *** hdl/aecp_counter_pair.sv ***
// Event counter pair: APB registers, counting and overflow flags
`timescale 1ns/1ns
module aecp_counter_pair #(
  parameter int AW = aecp_pkg::APB_AW
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic [AW-1:0]       paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata_r,
  output logic                     pready_r,
  output logic                     pslverr_r,
  input  wire logic                eventPinHigh,
  input  wire logic                eventPinLow,
  input  wire logic                gatePinInput,
  input  wire logic                gatePwmOutput,
  input  wire logic                gatePwmSelect,
  input  wire aecp_pkg::aecp_src_t srcHigh,
  input  wire aecp_pkg::aecp_src_t srcLow,
  input  wire logic [1:0]          gateEdgeSel,
  output logic      [7:0]          upperEventCounter_r,
  output logic      [7:0]          lowerEventCounter_r,
  output logic                     overflowIrqFlag_r
);

  aecp_pkg::aecp_ctrl_t   ctrl_r;
  aecp_pkg::aecp_ctrl_t   wrBits;
  aecp_pkg::aecp_apb_st_t apbSt_r;
  logic                   ovHighArmed_r;
  logic                   ovLowArmed_r;
  logic [7:0]             upper_nxt;
  logic [7:0]             lower_nxt;
  logic                   edgeHigh;
  logic                   edgeLow;
  logic                   gatePinSync;
  logic                   tick2;
  logic                   tick4;
  logic                   tick8;
  logic                   gateOn;
  logic                   tickHigh;
  logic                   tickLow;
  logic                   lowStep;
  logic                   highStep;
  logic                   ovHighEvent;
  logic                   ovLowEvent;
  logic                   access;
  logic                   done;
  logic                   wrCtrl;
  logic                   rdCtrl;
  logic                   ovHighClr;
  logic                   ovLowClr;
  logic                   mapped;
  logic [31:0]            rdMux;

  function automatic logic pickTick(
    input logic [1:0] sel,
    input logic       pinEdge,
    input logic       t2,
    input logic       t4,
    input logic       t8
  );
    case (sel)
      aecp_pkg::CLK_PIN:  pickTick = pinEdge;
      aecp_pkg::CLK_DIV2: pickTick = t2;
      aecp_pkg::CLK_DIV4: pickTick = t4;
      default:            pickTick = t8;
    endcase
  endfunction

  function automatic logic isAddr(
    input logic [AW-1:0] a,
    input logic [11:0]   ofs
  );
    isAddr = (a == AW'(ofs));
  endfunction

  aecp_edge_sync u_syncHigh (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pinIn     (eventPinHigh),
    .edgeSel   (srcHigh.edgeSel),
    .levelSync (),
    .edgeHit   (edgeHigh)
  );

  aecp_edge_sync u_syncLow (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pinIn     (eventPinLow),
    .edgeSel   (srcLow.edgeSel),
    .levelSync (),
    .edgeHit   (edgeLow)
  );

  // Only the level matters for gating; its edge output is left unconnected
  aecp_edge_sync u_syncGate (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pinIn     (gatePinInput),
    .edgeSel   (gateEdgeSel),
    .levelSync (gatePinSync),
    .edgeHit   ()
  );

  aecp_prescaler u_prescale (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick2   (tick2),
    .tick4   (tick4),
    .tick8   (tick8)
  );

  // Count qualification
  always_comb
  begin
    gateOn   = gatePwmSelect ? gatePwmOutput : gatePinSync;
    tickHigh = pickTick(srcHigh.clkSel, edgeHigh, tick2, tick4, tick8);
    tickLow  = pickTick(srcLow.clkSel, edgeLow, tick2, tick4, tick8);
    lowStep  = tickLow & ctrl_r.cueLow & ctrl_r.crcLow & gateOn;
    if (ctrl_r.split)
      highStep = tickHigh & ctrl_r.cueHigh & ctrl_r.crcHigh
                 & gateOn;
    else
      highStep = lowStep & (lowerEventCounter_r == aecp_pkg::COUNT_MAX)
                 & ctrl_r.cueHigh & ctrl_r.crcHigh;
    ovHighEvent = highStep
                  & (upperEventCounter_r == aecp_pkg::COUNT_MAX);
    ovLowEvent  = ctrl_r.split & lowStep
                  & (lowerEventCounter_r == aecp_pkg::COUNT_MAX);
  end

  // Next counter values
  always_comb
  begin
    upper_nxt = upperEventCounter_r;
    lower_nxt = lowerEventCounter_r;
    if (!ctrl_r.crcHigh)
      upper_nxt = aecp_pkg::COUNT_RESET;
    else if (highStep)
      upper_nxt = upperEventCounter_r + 8'h01;
    if (!ctrl_r.crcLow)
      lower_nxt = aecp_pkg::COUNT_RESET;
    else if (lowStep)
      lower_nxt = lowerEventCounter_r + 8'h01;
  end

  // Counters are never written by the bus
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      upperEventCounter_r <= aecp_pkg::COUNT_RESET;
      lowerEventCounter_r <= aecp_pkg::COUNT_RESET;
    end
    else
    begin
      upperEventCounter_r <= upper_nxt;
      lowerEventCounter_r <= lower_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      overflowIrqFlag_r <= 1'b0;
    else
      overflowIrqFlag_r <= ovHighEvent | ovLowEvent;
  end

  // APB decode; one wait state on every access
  always_comb
  begin
    access    = psel & penable;
    done      = access & pready_r;
    wrCtrl    = done & pwrite & isAddr(paddr, aecp_pkg::CTRL_OFS);
    rdCtrl    = done & ~pwrite & isAddr(paddr, aecp_pkg::CTRL_OFS);
    wrBits    = pwdata[$bits(aecp_pkg::aecp_ctrl_t)-1:0];
    mapped    = isAddr(paddr, aecp_pkg::CTRL_OFS)
                | isAddr(paddr, aecp_pkg::UPPER_OFS)
                | isAddr(paddr, aecp_pkg::LOWER_OFS);
    ovHighClr = wrCtrl & ~pwdata[aecp_pkg::OVH_BIT]
                & ovHighArmed_r;
    ovLowClr  = wrCtrl & ~pwdata[aecp_pkg::OVL_BIT]
                & ovLowArmed_r;
    rdMux     = aecp_pkg::RDATA_ZERO;
    if (isAddr(paddr, aecp_pkg::CTRL_OFS))
      rdMux[7:0] = ctrl_r;
    else if (isAddr(paddr, aecp_pkg::UPPER_OFS))
      rdMux[7:0] = upperEventCounter_r;
    else if (isAddr(paddr, aecp_pkg::LOWER_OFS))
      rdMux[7:0] = lowerEventCounter_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      apbSt_r   <= aecp_pkg::AECP_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= aecp_pkg::RDATA_ZERO;
    end
    else
    begin
      case (apbSt_r)
        aecp_pkg::AECP_IDLE:
        begin
          if (access)
          begin
            apbSt_r   <= aecp_pkg::AECP_DONE;
            pready_r  <= 1'b1;
            pslverr_r <= ~mapped;
            prdata_r  <= pwrite ? aecp_pkg::RDATA_ZERO : rdMux;
          end
        end
        aecp_pkg::AECP_DONE:
        begin
          apbSt_r   <= aecp_pkg::AECP_IDLE;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          prdata_r  <= aecp_pkg::RDATA_ZERO;
        end
        default:
        begin
          apbSt_r  <= aecp_pkg::AECP_IDLE;
          pready_r <= 1'b0;
        end
      endcase
    end
  end

  // One process owns the whole register; set beats clear, one is ignored
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_r <= aecp_pkg::CTRL_RESET;
    else
    begin
      if (wrCtrl)
      begin
        ctrl_r.reserved <= wrBits.reserved;
        ctrl_r.split    <= wrBits.split;
        ctrl_r.cueHigh  <= wrBits.cueHigh;
        ctrl_r.cueLow   <= wrBits.cueLow;
        ctrl_r.crcHigh  <= wrBits.crcHigh;
        ctrl_r.crcLow   <= wrBits.crcLow;
      end
      if (ovHighEvent)
        ctrl_r.ovHigh <= 1'b1;
      else if (ovHighClr)
        ctrl_r.ovHigh <= 1'b0;
      if (ovLowEvent)
        ctrl_r.ovLow <= 1'b1;
      else if (ovLowClr)
        ctrl_r.ovLow <= 1'b0;
    end
  end

  // Arming: a read that returned one permits the next clearing write
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovHighArmed_r <= 1'b0;
      ovLowArmed_r  <= 1'b0;
    end
    else
    begin
      if (rdCtrl && prdata_r[aecp_pkg::OVH_BIT])
        ovHighArmed_r <= 1'b1;
      else if (ovHighClr)
        ovHighArmed_r <= 1'b0;
      if (rdCtrl && prdata_r[aecp_pkg::OVL_BIT])
        ovLowArmed_r <= 1'b1;
      else if (ovLowClr)
        ovLowArmed_r <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence wrap16_s;
    !ctrl_r.split && highStep
      && upperEventCounter_r == aecp_pkg::COUNT_MAX
      && lowerEventCounter_r == aecp_pkg::COUNT_MAX;
  endsequence

  sequence zeroed16_s;
    upperEventCounter_r == aecp_pkg::COUNT_RESET
      && lowerEventCounter_r == aecp_pkg::COUNT_RESET && ctrl_r.ovHigh;
  endsequence

  ovh_set_a: assert property (
    ovHighEvent |=> ctrl_r.ovHigh)
    else $error("high overflow flag not set");
  ovl_split_a: assert property (
    $rose(ctrl_r.ovLow) |-> $past(ctrl_r.split) && $past(lowStep)
      && $past(lowerEventCounter_r) == aecp_pkg::COUNT_MAX)
    else $error("low overflow flag set outside split wrap");
  ovh_clear_a: assert property (
    $fell(ctrl_r.ovHigh) |-> $past(wrCtrl) && $past(ovHighArmed_r)
      && !$past(pwdata[aecp_pkg::OVH_BIT]))
    else $error("high flag cleared without read then write zero");
  ovl_clear_a: assert property (
    $fell(ctrl_r.ovLow) |-> $past(wrCtrl) && $past(ovLowArmed_r)
      && !$past(pwdata[aecp_pkg::OVL_BIT]))
    else $error("low flag cleared without read then write zero");
  flag_noset_a: assert property (
    $rose(ctrl_r.ovHigh) |-> $past(ovHighEvent))
    else $error("high flag set by something other than overflow");
  split_hold_a: assert property (
    ctrl_r.split && lowStep && !highStep && ctrl_r.crcHigh
      |=> upperEventCounter_r == $past(upperEventCounter_r))
    else $error("lower counter carried into upper in split mode");
  en_hold_a: assert property (
    ctrl_r.crcHigh && !ctrl_r.cueHigh
      |=> upperEventCounter_r == $past(upperEventCounter_r))
    else $error("upper counter moved while disabled");
  release_hold_a: assert property (
    !ctrl_r.crcLow |=> lowerEventCounter_r == aecp_pkg::COUNT_RESET)
    else $error("lower counter not held at zero");
  wrap16_a: assert property (
    wrap16_s |=> zeroed16_s)
    else $error("16-bit wrap did not zero and flag");
  gate_stop_a: assert property (
    !gateOn && ctrl_r.crcLow
      |=> lowerEventCounter_r == $past(lowerEventCounter_r))
    else $error("lower counter moved with gate low");
  irq_pulse_a: assert property (
    overflowIrqFlag_r == $past(ovHighEvent || ovLowEvent))
    else $error("overflow request pulse wrong");
  step_one_a: assert property (
    lowStep |=> lowerEventCounter_r == 8'($past(lowerEventCounter_r) + 1))
    else $error("lower counter did not step by one");

endmodule

// *** hdl/aecp_edge_sync.sv ***
// Pin synchroniser with selectable edge detection
`timescale 1ns/1ns
module aecp_edge_sync (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       pinIn,
  input  wire logic [1:0] edgeSel,
  output logic            levelSync,
  output logic            edgeHit
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign levelSync = sync2_r;

  // Prohibited select senses nothing
  always_comb
  begin
    case (edgeSel)
      aecp_pkg::EDGE_FALL: edgeHit = prev_r & ~sync2_r;
      aecp_pkg::EDGE_RISE: edgeHit = ~prev_r & sync2_r;
      aecp_pkg::EDGE_BOTH: edgeHit = prev_r ^ sync2_r;
      default:             edgeHit = 1'b0;
    endcase
  end

endmodule

// *** hdl/aecp_pkg.sv ***
// Shared constants and types of the event counter pair
package aecp_pkg;

  localparam int          APB_AW       = 12;
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] UPPER_OFS    = 12'h004;
  localparam logic [11:0] LOWER_OFS    = 12'h008;

  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  COUNT_RESET  = 8'h00;
  localparam logic [7:0]  COUNT_MAX    = 8'hff;
  localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

  localparam int          OVH_BIT      = 7;
  localparam int          OVL_BIT      = 6;

  // Input clock select
  localparam logic [1:0]  CLK_PIN      = 2'h0;
  localparam logic [1:0]  CLK_DIV2     = 2'h1;
  localparam logic [1:0]  CLK_DIV4     = 2'h2;
  localparam logic [1:0]  CLK_DIV8     = 2'h3;

  // Pin edge select
  localparam logic [1:0]  EDGE_FALL    = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_BOTH    = 2'h2;

  localparam int          PRESCALE_W   = 3;

  typedef struct packed {
    logic       ovHigh;
    logic       ovLow;
    logic       reserved;
    logic       split;
    logic       cueHigh;
    logic       cueLow;
    logic       crcHigh;
    logic       crcLow;
  } aecp_ctrl_t;

  typedef struct packed {
    logic [1:0] clkSel;
    logic [1:0] edgeSel;
  } aecp_src_t;

  typedef enum logic [1:0] {
    AECP_IDLE = 2'b01,
    AECP_DONE = 2'b10
  } aecp_apb_st_t;

endpackage

// *** hdl/aecp_prescaler.sv ***
// Free-running divider giving /2, /4 and /8 ticks
`timescale 1ns/1ns
module aecp_prescaler #(
  parameter int WIDTH = aecp_pkg::PRESCALE_W
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      tick2,
  output logic      tick4,
  output logic      tick8
);

  logic [WIDTH-1:0] div_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  assign tick2 = &div_r[0];
  assign tick4 = &div_r[1:0];
  assign tick8 = &div_r[2:0];

endmodule

// *** verification/aecp_counter_pair_tb_top.sv ***
// Self-checking bench of the event counter pair
`timescale 1ns/1ns
module aecp_counter_pair_tb_top;
  logic                sys_clk;
  logic                rst_n;
  logic [11:0]         paddr;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [31:0]         pwdata;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic                eventPinHigh;
  logic                eventPinLow;
  logic                gatePinInput;
  logic                gatePwmOutput;
  logic                gatePwmSelect;
  aecp_pkg::aecp_src_t srcHigh;
  aecp_pkg::aecp_src_t srcLow;
  logic [1:0]          gateEdgeSel;
  logic [7:0]          upperEventCounter_r;
  logic [7:0]          lowerEventCounter_r;
  logic                overflowIrqFlag_r;
  logic [31:0]         rd;
  logic                err;
  logic [7:0]          seed;
  logic [7:0]          hb;
  logic [7:0]          lb;
  int                  c;
  int                  cyc = 0;
  int                  irqCount = 0;
  int                  miscompares = 0;
  int                  nCompared = 0;

  aecp_counter_pair dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .eventPinHigh(eventPinHigh), .eventPinLow(eventPinLow),
    .gatePinInput(gatePinInput), .gatePwmOutput(gatePwmOutput),
    .gatePwmSelect(gatePwmSelect), .srcHigh(srcHigh), .srcLow(srcLow),
    .gateEdgeSel(gateEdgeSel), .upperEventCounter_r(upperEventCounter_r),
    .lowerEventCounter_r(lowerEventCounter_r),
    .overflowIrqFlag_r(overflowIrqFlag_r)
  );

  aecp_event_source src (
    .sys_clk(sys_clk), .pinHigh(eventPinHigh), .pinLow(eventPinLow),
    .gatePin(gatePinInput)
  );

  initial
    sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // Run needs about 2400 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (overflowIrqFlag_r === 1'b1)
      irqCount <= irqCount + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] ticks(input int n, input logic [1:0] sel);
    return 8'(n >> sel);
  endfunction

  task automatic end_sim();
    $display("compared %0d mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    nCompared++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never sees ready
    do
    begin
      @(posedge sys_clk);
    end
    while (pready_r !== 1'b1);
    rd  = prdata_r;
    err = pslverr_r;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d);
    apb(1'b1, aecp_pkg::CTRL_OFS, {24'h0, d});
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [7:0] e,
                       input string w);
    apb(1'b0, a, 32'h0);
    cmp(w, {24'h0, e}, rd);
  endtask

  task automatic snap();
    apb(1'b0, aecp_pkg::UPPER_OFS, 32'h0);
    hb = rd[7:0];
    apb(1'b0, aecp_pkg::LOWER_OFS, 32'h0);
    lb = rd[7:0];
  endtask

  task automatic delta(input logic [11:0] a, input logic [7:0] b,
                       input logic [7:0] e, input string w);
    apb(1'b0, a, 32'h0);
    cmp(w, e, 8'(rd[7:0] - b));
  endtask

  // Same-clock gate gives an exact window, whatever the divider phase
  task automatic win(input int n);
    @(posedge sys_clk);
    gatePwmOutput <= 1'b1;
    repeat (n) @(posedge sys_clk);
    gatePwmOutput <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic setSrc(input logic [1:0] h, input logic [1:0] l);
    @(posedge sys_clk);
    srcHigh <= '{clkSel: h, edgeSel: 2'h1};
    srcLow  <= '{clkSel: l, edgeSel: 2'h2};
  endtask

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    paddr = 12'h000;
    pwrite = 1'b0;
    pwdata = 32'h0;
    gatePwmOutput = 1'b0;
    gatePwmSelect = 1'b1;
    srcHigh = '0;
    srcLow = '0;
    gateEdgeSel = 2'h0;
    seed = 8'h38;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdChk(aecp_pkg::CTRL_OFS, 8'h00, "ctrl");
    rdChk(aecp_pkg::UPPER_OFS, 8'h00, "upper");
    rdChk(aecp_pkg::LOWER_OFS, 8'h00, "lower");
    apb(1'b0, 12'h00c, 32'h0);
    cmp("slverr", 32'h1, {31'h0, err});
    wr(8'h1c);
    setSrc(2'h1, 2'h1);
    win(64);
    rdChk(aecp_pkg::UPPER_OFS, 8'h00, "upper");
    rdChk(aecp_pkg::LOWER_OFS, 8'h00, "lower");
    wr(8'h13);
    // Released but frozen: a landed counter write would show as all ones
    apb(1'b1, aecp_pkg::UPPER_OFS, 32'hff);
    apb(1'b1, aecp_pkg::LOWER_OFS, 32'hff);
    win(64);
    rdChk(aecp_pkg::UPPER_OFS, 8'h00, "upper");
    rdChk(aecp_pkg::LOWER_OFS, 8'h00, "lower");
    wr(8'h1f);
    for (int k = 1; k < 4; k++)
    begin
      seed = lfsr(seed);
      c = (seed % 8 + 1) * 8;
      setSrc(2'(k), 2'(4 - k));
      snap();
      win(c);
      delta(aecp_pkg::UPPER_OFS, hb, ticks(c, 2'(k)), "upper");
      delta(aecp_pkg::LOWER_OFS, lb, ticks(c, 2'(4 - k)), "lower");
    end
    wr(8'h1c);
    wr(8'h1f);
    setSrc(2'h2, 2'h1);
    c = irqCount;
    win(512);
    rdChk(aecp_pkg::LOWER_OFS, 8'h00, "lower");
    rdChk(aecp_pkg::UPPER_OFS, 8'h80, "upper");
    wr(8'h1f);
    rdChk(aecp_pkg::CTRL_OFS, 8'h5f, "ctrl");
    wr(8'hdf);
    rdChk(aecp_pkg::CTRL_OFS, 8'h5f, "ctrl");
    wr(8'h1f);
    rdChk(aecp_pkg::CTRL_OFS, 8'h1f, "ctrl");
    setSrc(2'h1, 2'h3);
    win(256);
    rdChk(aecp_pkg::UPPER_OFS, 8'h00, "upper");
    rdChk(aecp_pkg::LOWER_OFS, 8'h20, "lower");
    rdChk(aecp_pkg::CTRL_OFS, 8'h9f, "ctrl");
    wr(8'h1f);
    rdChk(aecp_pkg::CTRL_OFS, 8'h1f, "ctrl");
    cmp("irq", 32'(c + 2), irqCount);
    wr(8'h0f);
    setSrc(2'h3, 2'h1);
    win(512);
    rdChk(aecp_pkg::UPPER_OFS, 8'h01, "upper");
    rdChk(aecp_pkg::LOWER_OFS, 8'h20, "lower");
    rdChk(aecp_pkg::CTRL_OFS, 8'h0f, "ctrl");
    // Fill both halves in split mode, then chain them one step short of wrap
    wr(8'h1c);
    wr(8'h1f);
    setSrc(2'h1, 2'h1);
    win(510);
    rdChk(aecp_pkg::UPPER_OFS, 8'hff, "upper");
    rdChk(aecp_pkg::LOWER_OFS, 8'hff, "lower");
    wr(8'h0f);
    win(2);
    rdChk(aecp_pkg::UPPER_OFS, 8'h00, "upper");
    rdChk(aecp_pkg::LOWER_OFS, 8'h00, "lower");
    rdChk(aecp_pkg::CTRL_OFS, 8'h8f, "ctrl");
    cmp("irq", 32'(c + 3), irqCount);
    wr(8'h1f);
    setSrc(2'h0, 2'h0);
    gatePwmSelect <= 1'b0;
    src.gate(1'b1);
    repeat (6) @(posedge sys_clk);
    snap();
    seed = lfsr(seed);
    c = seed % 8 + 1;
    src.toggles(1'b1, 2 * c, 2);
    src.toggles(1'b0, 2 * c, 5);
    repeat (6) @(posedge sys_clk);
    delta(aecp_pkg::UPPER_OFS, hb, 8'(c), "upper");
    delta(aecp_pkg::LOWER_OFS, lb, 8'(2 * c), "lower");
    src.gate(1'b0);
    repeat (6) @(posedge sys_clk);
    src.toggles(1'b1, 4, 3);
    repeat (6) @(posedge sys_clk);
    delta(aecp_pkg::UPPER_OFS, hb, 8'(c), "upper");
    end_sim();
  end
endmodule

// *** verification/aecp_event_source.sv ***
// Model of the external event pins and gate pin driving the counter pair
`timescale 1ns/1ns
module aecp_event_source (
  input  wire logic sys_clk,
  output logic      pinHigh,
  output logic      pinLow,
  output logic      gatePin
);
  initial
  begin
    pinHigh = 1'b0;
    pinLow  = 1'b0;
    gatePin = 1'b0;
  end

  // Half periods of 2 or more keep edges within the synchroniser's reach
  task automatic toggles(input bit side, input int n, input int half);
    for (int i = 0; i < n; i++)
    begin
      repeat (half) @(posedge sys_clk);
      if (side)
        pinHigh <= ~pinHigh;
      else
        pinLow <= ~pinLow;
    end
  endtask

  task automatic gate(input logic v);
    @(posedge sys_clk);
    gatePin <= v;
  endtask
endmodule
